// *** rtl/airs_pkg.sv ***
// Constants, register map and encodings for the analog input and relay select block.
// Overview of operation
// - Input one decodes eight signal formats.
// - Unipolar voltage: negative reference clamps to zero.
// - Bipolar voltage: negative reference selects reverse rotation.
// - Trip current formats: loss under 3 mA trips.
// - Ramp current formats: loss under 3 mA ramps.
// - Inverted current maps 20 mA minimum, 4 mA maximum.
// - Signed percent offset subtracted from input one only, default zero, +/-500.
// - Percent scaling multiplies input one only, default 100, 200 doubles.
// - Input two decodes six formats, no bipolar.
// - Relay selector routes condition, default one, high closes.
// - Selection 0: relay high while running.
// - Selection 1: relay high when ready, no fault.
// - Selection 2: relay high at target frequency.
// - Selection 3: relay high while tripped.
// - Selection 4: frequency at or above threshold.
// - Selection 5: current at or above threshold.
// - Selection 6: frequency below threshold.
// - Selection 7: current below threshold.
package airs_pkg;
    localparam logic [4:0] REG_CTRL = 5'h00;
    localparam logic [4:0] REG_OFFSET = 5'h04;
    localparam logic [4:0] REG_SCALE = 5'h08;
    localparam logic [4:0] REG_THRESH = 5'h0C;
    localparam logic [4:0] REG_STATUS = 5'h10;
    localparam logic [4:0] REG_REF1 = 5'h14;
    localparam logic [4:0] REG_REF2 = 5'h18;
    localparam logic [4:0] REG_FAULT = 5'h1C;
    localparam int CTRL_FMT1_LSB = 0;
    localparam int CTRL_FMT2_LSB = 4;
    localparam int CTRL_RELAY_LSB = 8;
    localparam logic [2:0] FMT1_RESET = 3'h0;
    localparam logic [2:0] FMT2_RESET = 3'h0;
    localparam logic [2:0] RELAY_RESET = 3'h1;
    localparam logic signed [15:0] OFFSET_RESET = 16'sh0000;
    localparam logic signed [15:0] OFFSET_MAX = 16'sh1388;
    localparam logic signed [15:0] OFFSET_MIN = -16'sh1388;
    localparam logic [15:0] SCALE_RESET = 16'h03E8;
    localparam logic [15:0] SCALE_MAX = 16'h4E20;
    localparam logic [15:0] THRESH_RESET = 16'h0000;
    localparam logic [11:0] ADC_FULL = 12'hFFF;
    localparam logic [11:0] ADC_4MA = 12'h333;
    localparam logic [11:0] ADC_3MA = 12'h266;
    localparam logic [11:0] ADC_SPAN_4_20 = 12'hCCC;
    localparam logic signed [11:0] PCT_FULL = 12'sh3E8;
    localparam logic [7:0] LOSS_FAULT_CODE = 8'h07;
    localparam int CLK_PERIOD_NS = 100;
    localparam int UPDATE_PERIOD_US = 1000;
    localparam int UPDATE_CYCLES = UPDATE_PERIOD_US * 1000 / CLK_PERIOD_NS;
    typedef enum logic [2:0] {
        FMT_VOLT_UNI, FMT_VOLT_BI, FMT_CUR_0_20, FMT_CUR_4_20_TRIP,
        FMT_CUR_4_20_RAMP, FMT_CUR_20_4_TRIP, FMT_CUR_20_4_RAMP, FMT_POT
    } airs_fmt_type;
    typedef enum logic [2:0] {
        RLY_RUNNING, RLY_READY, RLY_AT_TARGET, RLY_TRIPPED,
        RLY_FREQ_GE, RLY_CUR_GE, RLY_FREQ_LT, RLY_CUR_LT
    } airs_relay_type;
endpackage : airs_pkg

// *** rtl/airs_input_cond.sv ***
// Converts one raw analog sample into a percent reference with loss detection.
`timescale 1ns/10ps
`default_nettype none
module airs_input_cond
    import airs_pkg::*;
(
    input wire logic [2:0] fmt_i,
    input wire logic [11:0] sample_i,
    input wire logic [11:0] pot_i,
    output logic signed [11:0] pct_o,
    output logic loss_o,
    output logic trip_var_o,
    output logic ramp_var_o
);
    logic [23:0] lin;
    logic [23:0] bip;
    logic [23:0] loop;
    logic [11:0] above4;

    always_comb begin
        above4 = (sample_i > ADC_4MA) ? sample_i - ADC_4MA : 12'h000;
        lin = ({12'h000, sample_i} * 24'h00_03E8) / {12'h000, ADC_FULL};
        bip = ({12'h000, sample_i} * 24'h00_07D0) / {12'h000, ADC_FULL};
        loop = ({12'h000, above4} * 24'h00_03E8) / {12'h000, ADC_SPAN_4_20};
        if (loop > 24'h00_03E8) begin
            loop = 24'h00_03E8;
        end
        case (airs_fmt_type'(fmt_i))
            FMT_VOLT_BI: pct_o = $signed(bip[11:0]) - PCT_FULL;
            FMT_CUR_4_20_TRIP, FMT_CUR_4_20_RAMP: pct_o = $signed(loop[11:0]);
            FMT_CUR_20_4_TRIP, FMT_CUR_20_4_RAMP: pct_o = PCT_FULL - $signed(loop[11:0]);
            FMT_POT: pct_o = $signed(12'(({12'h000, pot_i} * 24'h00_03E8) / {12'h000, ADC_FULL}));
            default: pct_o = $signed(lin[11:0]);
        endcase
        trip_var_o = (fmt_i == FMT_CUR_4_20_TRIP) || (fmt_i == FMT_CUR_20_4_TRIP);
        ramp_var_o = (fmt_i == FMT_CUR_4_20_RAMP) || (fmt_i == FMT_CUR_20_4_RAMP);
        loss_o = (trip_var_o || ramp_var_o) && (sample_i < ADC_3MA);
    end
endmodule // airs_input_cond
`default_nettype wire

// *** rtl/airs_top.sv ***
// Analog reference conditioning, loss handling and relay selection with an Avalon slave.
`timescale 1ns/10ps
`default_nettype none
module airs_top
    import airs_pkg::*;
#(
    parameter int UPDATE_CYCLES_P = UPDATE_CYCLES
) (
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    input wire logic [4:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic [11:0] ai1_sample_i,
    input wire logic [11:0] ai2_sample_i,
    input wire logic [11:0] pot_sample_i,
    input wire logic drive_running_i,
    input wire logic power_ok_i,
    input wire logic fault_active_i,
    input wire logic fault_latched_i,
    input wire logic fault_reset_i,
    input wire logic [15:0] out_freq_i,
    input wire logic [15:0] setpoint_freq_i,
    input wire logic [15:0] motor_current_i,
    output logic relay_o,
    output logic [11:0] ref1_o,
    output logic reverse_o,
    output logic [11:0] ref2_o,
    output logic ai1_loss_o,
    output logic ai2_loss_o,
    output logic trip_request_o,
    output logic ramp_stop_o,
    output logic [7:0] fault_code_o
);
    logic [2:0] fmt1;
    logic [2:0] fmt2;
    logic [2:0] relay_sel;
    logic signed [15:0] offset;
    logic [15:0] scale;
    logic [15:0] thresh;
    logic ack;
    logic [31:0] next_readdata;
    logic [13:0] tick_cnt;
    logic tick;
    logic signed [11:0] pct1;
    logic signed [11:0] pct2;
    logic loss1;
    logic loss2;
    logic trip1;
    logic trip2;
    logic ramp1;
    logic ramp2;
    logic signed [33:0] prod;
    logic signed [33:0] ref1_full;
    logic [11:0] next_ref1;
    logic next_reverse;
    logic [7:0] cond;

    // Maps the six input-two format codes onto the common format encoding.
    function automatic logic [2:0] fmt2_map(input logic [2:0] code);
        if (code == 3'h0 || code > 3'h5) begin
            return FMT_VOLT_UNI;
        end
        return code + 3'h1;
    endfunction

    // Keeps a written offset inside its legal range.
    function automatic logic signed [15:0] clamp_offset(input logic signed [15:0] v);
        if (v > OFFSET_MAX) begin
            return OFFSET_MAX;
        end
        if (v < OFFSET_MIN) begin
            return OFFSET_MIN;
        end
        return v;
    endfunction

    // One wait state: the request is answered in the cycle after it is seen.
    assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack;

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ack <= 1'b0;
        end else begin
            ack <= (avs_read_i || avs_write_i) && !ack;
        end
    end

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            fmt1 <= FMT1_RESET;
            fmt2 <= FMT2_RESET;
            relay_sel <= RELAY_RESET;
            offset <= OFFSET_RESET;
            scale <= SCALE_RESET;
            thresh <= THRESH_RESET;
        end else if (avs_write_i && ack) begin
            case (avs_address_i)
                REG_CTRL: begin
                    if (avs_byteenable_i[0]) begin
                        fmt1 <= avs_writedata_i[CTRL_FMT1_LSB +: 3];
                        fmt2 <= avs_writedata_i[CTRL_FMT2_LSB +: 3];
                    end
                    if (avs_byteenable_i[1]) begin
                        relay_sel <= avs_writedata_i[CTRL_RELAY_LSB +: 3];
                    end
                end
                REG_OFFSET: begin
                    if (&avs_byteenable_i[1:0]) begin
                        offset <= clamp_offset($signed(avs_writedata_i[15:0]));
                    end
                end
                REG_SCALE: begin
                    if (&avs_byteenable_i[1:0]) begin
                        scale <= (avs_writedata_i[15:0] > SCALE_MAX) ? SCALE_MAX
                                 : avs_writedata_i[15:0];
                    end
                end
                REG_THRESH: begin
                    if (&avs_byteenable_i[1:0]) begin
                        thresh <= avs_writedata_i[15:0];
                    end
                end
                default: begin
                end
            endcase
        end
    end

    always_comb begin
        case (avs_address_i)
            REG_CTRL: next_readdata = {21'h00_0000, relay_sel, 1'b0, fmt2, 1'b0, fmt1};
            REG_OFFSET: next_readdata = {16'h0000, offset};
            REG_SCALE: next_readdata = {16'h0000, scale};
            REG_THRESH: next_readdata = {16'h0000, thresh};
            REG_STATUS: next_readdata = {26'h000_0000, ramp_stop_o, trip_request_o,
                                         ai2_loss_o, ai1_loss_o, reverse_o, relay_o};
            REG_REF1: next_readdata = {20'h0_0000, ref1_o};
            REG_REF2: next_readdata = {20'h0_0000, ref2_o};
            REG_FAULT: next_readdata = {24'h00_0000, fault_code_o};
            default: next_readdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            avs_readdata_o <= 32'h0000_0000;
        end else if (avs_read_i && !ack) begin
            avs_readdata_o <= next_readdata;
        end
    end

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            tick_cnt <= 14'h0000;
        end else if (tick) begin
            tick_cnt <= 14'h0000;
        end else begin
            tick_cnt <= tick_cnt + 14'h0001;
        end
    end

    assign tick = (tick_cnt == 14'(UPDATE_CYCLES_P - 1));

    airs_input_cond u_cond1 (
        .fmt_i(fmt1),
        .sample_i(ai1_sample_i),
        .pot_i(pot_sample_i),
        .pct_o(pct1),
        .loss_o(loss1),
        .trip_var_o(trip1),
        .ramp_var_o(ramp1)
    );

    airs_input_cond u_cond2 (
        .fmt_i(fmt2_map(fmt2)),
        .sample_i(ai2_sample_i),
        .pot_i(pot_sample_i),
        .pct_o(pct2),
        .loss_o(loss2),
        .trip_var_o(trip2),
        .ramp_var_o(ramp2)
    );

    // Offset is subtracted first, then the scale factor in tenths of a percent applies.
    always_comb begin
        prod = 34'(pct1 - offset) * $signed({18'h0_0000, scale});
        ref1_full = prod / 34'sh0_0000_03E8;
        next_reverse = 1'b0;
        if (ref1_full < 0) begin
            if (fmt1 == FMT_VOLT_BI) begin
                next_reverse = 1'b1;
                ref1_full = -ref1_full;
            end else begin
                ref1_full = '0;
            end
        end
        if (ref1_full > 34'sh0_0000_03E8) begin
            ref1_full = 34'sh0_0000_03E8;
        end
        next_ref1 = ref1_full[11:0];
    end

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ref1_o <= 12'h000;
            reverse_o <= 1'b0;
            ref2_o <= 12'h000;
        end else if (tick) begin
            ref1_o <= next_ref1;
            reverse_o <= next_reverse;
            ref2_o <= pct2[11:0];
        end
    end

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ai1_loss_o <= 1'b0;
            ai2_loss_o <= 1'b0;
            ramp_stop_o <= 1'b0;
        end else if (tick) begin
            ai1_loss_o <= loss1;
            ai2_loss_o <= loss2;
            ramp_stop_o <= (loss1 && ramp1) || (loss2 && ramp2);
        end
    end

    // A new loss event wins over a fault reset in the same cycle.
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            trip_request_o <= 1'b0;
            fault_code_o <= 8'h00;
        end else if (tick && ((loss1 && trip1) || (loss2 && trip2))) begin
            trip_request_o <= 1'b1;
            fault_code_o <= LOSS_FAULT_CODE;
        end else if (fault_reset_i) begin
            trip_request_o <= 1'b0;
            fault_code_o <= 8'h00;
        end
    end

    always_comb begin
        cond[RLY_RUNNING] = drive_running_i;
        cond[RLY_READY] = power_ok_i && !fault_active_i;
        cond[RLY_AT_TARGET] = (out_freq_i == setpoint_freq_i);
        cond[RLY_TRIPPED] = fault_latched_i;
        cond[RLY_FREQ_GE] = (out_freq_i >= thresh);
        cond[RLY_CUR_GE] = (motor_current_i >= thresh);
        cond[RLY_FREQ_LT] = (out_freq_i < thresh);
        cond[RLY_CUR_LT] = (motor_current_i < thresh);
    end

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            relay_o <= 1'b0;
        end else if (tick) begin
            relay_o <= cond[relay_sel];
        end
    end

    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!reset_n_i);

    a_relay_running: assert property (tick && relay_sel == RLY_RUNNING
        |=> relay_o == $past(drive_running_i)) else $error("relay not running");
    a_relay_ready: assert property (tick && relay_sel == RLY_READY
        |=> relay_o == $past(power_ok_i && !fault_active_i)) else $error("relay not ready");
    a_relay_target: assert property (tick && relay_sel == RLY_AT_TARGET
        |=> relay_o == ($past(out_freq_i) == $past(setpoint_freq_i)))
        else $error("relay not at target");
    a_relay_tripped: assert property (tick && relay_sel == RLY_TRIPPED
        |=> relay_o == $past(fault_latched_i)) else $error("relay not tripped");
    a_relay_freq_ge: assert property (tick && relay_sel == RLY_FREQ_GE
        |=> relay_o == ($past(out_freq_i) >= $past(thresh))) else $error("relay freq ge");
    a_relay_cur_ge: assert property (tick && relay_sel == RLY_CUR_GE
        |=> relay_o == ($past(motor_current_i) >= $past(thresh)))
        else $error("relay cur ge");
    a_relay_freq_lt: assert property (tick && relay_sel == RLY_FREQ_LT
        |=> relay_o == ($past(out_freq_i) < $past(thresh)))
        else $error("relay freq lt");
    a_relay_cur_lt: assert property (tick && relay_sel == RLY_CUR_LT
        |=> relay_o == ($past(motor_current_i) < $past(thresh))) else $error("relay cur lt");
    a_relay_hold_tick: assert property (!tick |=> $stable(relay_o))
        else $error("relay moved off tick");
    a_ref_hold: assert property (!tick
        |=> $stable(ref1_o) && $stable(ref2_o) && $stable(reverse_o))
        else $error("reference moved off tick");
    a_loss1_flag: assert property (tick
        |=> ai1_loss_o == $past(loss1))
        else $error("input one loss flag wrong");
    a_loss2_flag: assert property (tick
        |=> ai2_loss_o == $past(loss2))
        else $error("input two loss flag wrong");
    a_loss_hold: assert property (!tick
        |=> $stable(ai1_loss_o) && $stable(ai2_loss_o))
        else $error("loss flag moved off tick");

    a_uni_no_reverse: assert property (tick && fmt1 != FMT_VOLT_BI |=> !reverse_o)
        else $error("reverse without bipolar");
    a_uni_clamp_zero: assert property (tick && fmt1 == FMT_VOLT_UNI && pct1 < offset
        |=> ref1_o == 12'h000)
        else $error("negative reference not clamped");
    a_bi_neg_reverse: assert property (tick && fmt1 == FMT_VOLT_BI && next_ref1 != 12'h000
        && next_reverse |=> reverse_o && ref1_o == $past(next_ref1))
        else $error("bipolar reverse lost");
    a_loss_trip_set: assert property (tick && loss1 && trip1
        |=> trip_request_o && fault_code_o == LOSS_FAULT_CODE)
        else $error("trip not latched");
    a_trip_sticky: assert property (trip_request_o && !fault_reset_i
        |=> trip_request_o && fault_code_o == LOSS_FAULT_CODE)
        else $error("trip dropped without reset");
    a_trip_input2: assert property (tick && loss2 && trip2
        |=> trip_request_o && fault_code_o == LOSS_FAULT_CODE)
        else $error("input two trip not latched");
    a_trip_clear: assert property (fault_reset_i
        && !(tick && ((loss1 && trip1) || (loss2 && trip2)))
        |=> !trip_request_o && fault_code_o == 8'h00) else $error("trip not cleared");
    a_loss_ramp: assert property (tick && loss1 && ramp1 && !(loss2 && trip2)
        |=> ramp_stop_o && !$rose(trip_request_o)) else $error("ramp not requested");
    a_ramp_input2: assert property (tick && loss2 && ramp2
        |=> ramp_stop_o)
        else $error("input two ramp not requested");
    a_ramp_clear: assert property (tick && !(loss1 && ramp1) && !(loss2 && ramp2)
        |=> !ramp_stop_o)
        else $error("ramp request stuck");
    a_ref_limit: assert property (ref1_o <= 12'h3E8)
        else $error("reference above full scale");
    a_bus_answer: assert property ((avs_read_i || avs_write_i) && !ack
        |=> !avs_waitrequest_o) else $error("bus answer late");

    c_trip: cover property (tick && loss1 && trip1);
    c_ramp: cover property (tick && loss2 && ramp2);
    c_reverse: cover property ($rose(reverse_o));
    c_relay_freq: cover property (tick && relay_sel == RLY_FREQ_LT ##1 relay_o);
    c_relay_target: cover property (tick && relay_sel == RLY_AT_TARGET ##1 relay_o);
endmodule // airs_top
`default_nettype wire

// *** testbench/airs_field_model.sv ***
// Far-side model: loop sources feeding the converters and the relay contact load.
`timescale 1ns/10ps
`default_nettype none
module airs_field_model (
    input wire logic [15:0] ai1_ua_i,
    input wire logic [15:0] ai2_ua_i,
    input wire logic [15:0] pot_ua_i,
    input wire logic relay_i,
    output logic [11:0] ai1_sample_o,
    output logic [11:0] ai2_sample_o,
    output logic [11:0] pot_sample_o,
    output logic contact_closed_o
);
    // Levels are in microamps; a voltage source uses 20000 for 10 V.
    assign ai1_sample_o = 12'((32'(ai1_ua_i) * 4095) / 20000);
    assign ai2_sample_o = 12'((32'(ai2_ua_i) * 4095) / 20000);
    assign pot_sample_o = 12'((32'(pot_ua_i) * 4095) / 20000);
    assign contact_closed_o = relay_i;
endmodule // airs_field_model
`default_nettype wire

// *** testbench/tb.sv ***
// Self-checking bench for the analog input and relay select block.
`timescale 1ns/10ps
`default_nettype none
module tb;
    import airs_pkg::*;
    localparam int UPD = 8;
    logic ref_clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic [4:0] adr = 5'h00;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdat = 32'h0000_0000;
    logic [3:0] be = 4'h0;
    logic run = 1'b0, pwr = 1'b0, fact = 1'b0, flat = 1'b0, frst = 1'b0;
    logic [15:0] ofq = 16'h0000, sfq = 16'h0000, cur = 16'h0000;
    logic [15:0] ua1 = 16'h0000, ua2 = 16'h0000, uap = 16'h0000;
    logic [31:0] rdat;
    logic wt, relay, rev, l1, l2, trip, ramp, closed;
    logic [11:0] s1, s2, sp, ref1, ref2;
    logic [7:0] fcode;
    int fails = 0;
    int checked = 0;
    always #50 ref_clk_i = ~ref_clk_i;
    airs_field_model u_src (.ai1_ua_i(ua1), .ai2_ua_i(ua2), .pot_ua_i(uap), .relay_i(relay),
        .ai1_sample_o(s1), .ai2_sample_o(s2), .pot_sample_o(sp), .contact_closed_o(closed));
    airs_top #(.UPDATE_CYCLES_P(UPD)) u_dut (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
        .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat),
        .avs_byteenable_i(be), .avs_readdata_o(rdat), .avs_waitrequest_o(wt),
        .ai1_sample_i(s1), .ai2_sample_i(s2), .pot_sample_i(sp), .drive_running_i(run),
        .power_ok_i(pwr), .fault_active_i(fact), .fault_latched_i(flat), .fault_reset_i(frst),
        .out_freq_i(ofq), .setpoint_freq_i(sfq), .motor_current_i(cur), .relay_o(relay),
        .ref1_o(ref1), .reverse_o(rev), .ref2_o(ref2), .ai1_loss_o(l1), .ai2_loss_o(l2),
        .trip_request_o(trip), .ramp_stop_o(ramp), .fault_code_o(fcode));
    task automatic report_and_stop();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            fails++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    // One Avalon transfer; the request is held until waitrequest is seen low.
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
            input logic [3:0] b, output logic [31:0] q);
        bit done;
        done = 1'b0;
        q = 32'h0000_0000;
        @(posedge ref_clk_i);
        adr <= a;
        rd <= !w;
        wr <= w;
        wdat <= d;
        be <= b;
        for (int i = 0; i < 20 && !done; i++) begin
            @(posedge ref_clk_i);
            done = (wt === 1'b0);
        end
        if (done) begin
            q = rdat;
        end
        rd <= 1'b0;
        wr <= 1'b0;
        if (!done) begin
            fails++;
            report_and_stop();
        end
    endtask
    task automatic wreg(input logic [4:0] a, input logic [31:0] d, input logic [3:0] b);
        logic [31:0] q;
        bus(1'b1, a, d, b, q);
    endtask
    task automatic rchk(input string nm, input logic [4:0] a, input logic [31:0] m,
            input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0000_0000, 4'hF, q);
        chk(nm, e, q & m);
    endtask
    task automatic settle();
        repeat (2 * UPD + 2) @(posedge ref_clk_i);
        @(negedge ref_clk_i);
    endtask
    task automatic src(input logic [15:0] a1, input logic [15:0] a2);
        @(posedge ref_clk_i);
        ua1 <= a1;
        ua2 <= a2;
        settle();
    endtask
    task automatic fmt(input int f1, input int f2);
        wreg(REG_CTRL, 32'((f2 << CTRL_FMT2_LSB) | (f1 << CTRL_FMT1_LSB)), 4'h1);
    endtask
    task automatic clear_trip();
        @(posedge ref_clk_i);
        frst <= 1'b1;
        @(posedge ref_clk_i);
        frst <= 1'b0;
        settle();
        chk("trip cleared", 32'h0, 32'(trip));
        chk("code cleared", 32'h0, 32'(fcode));
    endtask
    task automatic loss_chk(input logic e1, input logic e2, input logic et, input logic er);
        chk("loss1", 32'(e1), 32'(l1));
        chk("loss2", 32'(e2), 32'(l2));
        chk("trip", 32'(et), 32'(trip));
        chk("ramp", 32'(er), 32'(ramp));
        chk("fault code", et ? 32'(LOSS_FAULT_CODE) : 32'h0, 32'(fcode));
    endtask
    task automatic sweep(input logic [15:0] f, input logic [15:0] c, input logic [7:0] e);
        @(posedge ref_clk_i);
        run <= e[0];
        fact <= !e[1];
        flat <= e[3];
        ofq <= f;
        sfq <= 16'h01F4;
        cur <= c;
        for (int s = 0; s < 8; s++) begin
            wreg(REG_CTRL, 32'(s) << CTRL_RELAY_LSB, 4'h2);
            settle();
            chk("relay", 32'(e[s]), 32'(relay));
            chk("contact", 32'(e[s]), 32'(closed));
        end
    endtask
    initial begin
        repeat (60000) @(posedge ref_clk_i);
        fails++;
        report_and_stop();
    end
    initial begin
        repeat (8) @(posedge ref_clk_i);
        pwr <= 1'b1;
        chk("relay in reset", 32'h0, 32'(relay));
        reset_n_i <= 1'b1;
        rchk("ctrl", REG_CTRL, 32'h0000_0777, 32'h0000_0100);
        rchk("offset", REG_OFFSET, 32'h0000_FFFF, 32'h0000_0000);
        rchk("scale", REG_SCALE, 32'h0000_FFFF, 32'h0000_03E8);
        wreg(REG_OFFSET, 32'h0000_7FFF, 4'h3);
        rchk("offset hi", REG_OFFSET, 32'h0000_FFFF, 32'h0000_1388);
        wreg(REG_OFFSET, 32'h0000_8000, 4'h3);
        rchk("offset lo", REG_OFFSET, 32'h0000_FFFF, 32'h0000_EC78);
        wreg(REG_SCALE, 32'h0000_FFFF, 4'h3);
        wreg(REG_SCALE, 32'h0000_0001, 4'h1);
        rchk("scale hi", REG_SCALE, 32'h0000_FFFF, 32'h0000_4E20);
        wreg(REG_SCALE, 32'h0000_03E8, 4'h3);
        wreg(REG_OFFSET, 32'h0000_00C8, 4'h3);
        src(16'd20000, 16'd20000);
        chk("ref1 offset", 32'd800, 32'(ref1));
        src(16'd0, 16'd20000);
        chk("ref1 clamp", 32'd0, 32'(ref1));
        chk("rev uni", 32'h0, 32'(rev));
        fmt(1, 0);
        src(16'd20000, 16'd20000);
        chk("rev fwd", 32'h0, 32'(rev));
        src(16'd0, 16'd20000);
        chk("rev bi", 32'h1, 32'(rev));
        fmt(0, 0);
        wreg(REG_OFFSET, 32'h0000_0000, 4'h3);
        wreg(REG_SCALE, 32'h0000_07D0, 4'h3);
        src(16'd10010, 16'd20000);
        chk("ref1 scaled", 32'd1000, 32'(ref1));
        wreg(REG_SCALE, 32'h0000_03E8, 4'h3);
        fmt(3, 0);
        src(16'd3100, 16'd20000);
        loss_chk(1'b0, 1'b0, 1'b0, 1'b0);
        src(16'd2900, 16'd20000);
        loss_chk(1'b1, 1'b0, 1'b1, 1'b0);
        rchk("status", REG_STATUS, 32'h0000_003C, 32'h0000_0014);
        rchk("fault reg", REG_FAULT, 32'h0000_00FF, 32'(LOSS_FAULT_CODE));
        src(16'd20000, 16'd20000);
        clear_trip();
        fmt(4, 0);
        src(16'd2900, 16'd20000);
        loss_chk(1'b1, 1'b0, 1'b0, 1'b1);
        fmt(5, 0);
        src(16'd20000, 16'd20000);
        chk("ref1 20ma", 32'd0, 32'(ref1));
        src(16'd4000, 16'd20000);
        chk("ref1 4ma", 32'd1000, 32'(ref1));
        src(16'd2900, 16'd20000);
        loss_chk(1'b1, 1'b0, 1'b1, 1'b0);
        src(16'd20000, 16'd20000);
        clear_trip();
        fmt(6, 0);
        src(16'd2900, 16'd20000);
        loss_chk(1'b1, 1'b0, 1'b0, 1'b1);
        fmt(2, 0);
        settle();
        loss_chk(1'b0, 1'b0, 1'b0, 1'b0);
        fmt(7, 0);
        uap <= 16'd20000;
        src(16'd0, 16'd20000);
        chk("ref1 pot", 32'd1000, 32'(ref1));
        for (int f = 0; f < 6; f++) begin
            fmt(0, f);
            src(16'd20000, 16'd20000);
            chk("ref2", (f < 4) ? 32'd1000 : 32'd0, 32'(ref2));
            src(16'd20000, 16'd2900);
            loss_chk(1'b0, f > 1, f == 2 || f == 4, f == 3 || f == 5);
            src(16'd20000, 16'd20000);
            clear_trip();
        end
        wreg(REG_THRESH, 32'h0000_01F4, 4'h3);
        sweep(16'h01F4, 16'h012C, 8'h97);
        sweep(16'h01F3, 16'h01F4, 8'h68);
        report_and_stop();
    end
endmodule // tb
`default_nettype wire
